// ===== hdl/pwp_pkg.sv
// Purpose: Shared constants and types of the write protection and
//          driver supply low response block.
// Assumes: 125 MHz clock, command codes of eight bits.
// Notes:   Offsets are command codes.
package pwp_pkg;
    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [7:0] PWP_CMD_LOW_ACTION = 8'hf9;
    localparam logic [7:0] PWP_CMD_LEVEL = 8'hfa;
    localparam logic [7:0] PWP_CMD_USER_KEY = 8'hfb;
    localparam logic [7:0] PWP_CMD_LOCK_KEY = 8'hfc;
    localparam logic [7:0] PWP_CMD_WRITE_MASK = 8'hfd;

    // ----------------------------------------
    // Fields of driver_supply_low_action
    // ----------------------------------------
    localparam int PWP_RESP_MSB = 7;
    localparam int PWP_RESP_LSB = 6;
    localparam int PWP_RETRY_MSB = 5;
    localparam int PWP_RETRY_LSB = 3;
    localparam int PWP_RTIME_MSB = 2;
    localparam int PWP_RTIME_LSB = 0;
    localparam logic [1:0] PWP_RESP_IGNORE = 2'h0;
    localparam logic [1:0] PWP_RESP_RETRY = 2'h2;
    localparam logic [1:0] PWP_RESP_RESUME = 2'h3;
    localparam logic [2:0] PWP_RETRY_NONE = 3'h0;
    localparam logic [2:0] PWP_RETRY_FOREVER = 3'h7;

    // ----------------------------------------
    // Widths and reset values
    // ----------------------------------------
    localparam int PWP_USER_KEY_W = 72;
    localparam int PWP_LOCK_KEY_W = 32;
    localparam int PWP_MASK_W = 256;
    localparam logic [7:0] PWP_ACTION_RST = 8'h00;
    localparam logic [71:0] PWP_USER_KEY_RST = 72'h0;
    localparam logic [31:0] PWP_LOCK_KEY_RST = 32'h0;
    localparam logic [255:0] PWP_MASK_RST = {256{1'b1}};

    // ----------------------------------------
    // Protection levels
    // ----------------------------------------
    localparam logic [1:0] PWP_LVL_OPEN = 2'h0;
    localparam logic [1:0] PWP_LVL_PUBLIC = 2'h1;
    localparam logic [1:0] PWP_LVL_USER = 2'h2;
    localparam logic [1:0] PWP_LVL_VENDOR = 2'h3;

    // ----------------------------------------
    // Thresholds in percent
    // ----------------------------------------
    localparam logic [7:0] PWP_PCT_FULL = 8'd100;
    localparam logic [7:0] PWP_PCT_RESUME = 8'd105;
    localparam logic [7:0] PWP_PCT_WARN = 8'd110;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int PWP_CLK_KHZ = 125000;
    localparam int PWP_RETRY_STEP_MS = 35;
    localparam int PWP_RETRY_STEP_CYC = PWP_RETRY_STEP_MS * PWP_CLK_KHZ;

    typedef enum logic [1:0] {
        PWP_ST_RUN,
        PWP_ST_WAIT,
        PWP_ST_HOLD,
        PWP_ST_RESUME
    } pwp_state_t;
endpackage

// ===== hdl/pwp_guard_if.sv
// Purpose: Carries a command code and protection state to the guard.
// Assumes: One clock domain.
// Notes:   Purely combinational signals.
`timescale 1ns/100ps
interface pwp_guard_if;
    logic [7:0] code;
    logic [1:0] level;
    logic [255:0] user_mask;
    logic [255:0] dflt_mask;
    logic allowed;
    modport core (output code, output level, output user_mask, output dflt_mask, input allowed);
    modport guard (input code, input level, input user_mask, input dflt_mask, output allowed);
endinterface

// ===== hdl/pwp_guard.sv
// Purpose: Decides whether one command code may be written now.
// Assumes: Masks and level come from the register core.
// Notes:   Mask bit n belongs to command code n.
`timescale 1ns/100ps
module pwp_guard
    import pwp_pkg::*;
(
    pwp_guard_if.guard gi
);
    // ----------------------------------------
    // Permission decode
    // ----------------------------------------
    always_comb begin
        if (!gi.dflt_mask[gi.code]) begin
            gi.allowed = (gi.level >= PWP_LVL_VENDOR);
        end else if (!gi.user_mask[gi.code]) begin
            gi.allowed = (gi.level >= PWP_LVL_USER);
        end else begin
            gi.allowed = 1'b1;
        end
    end
endmodule

// ===== hdl/pwp_core.sv
// Purpose: Command level write protection and driver supply low response.
// Assumes: Command port already decoded from the bus transaction.
// Notes:   Fault limit and default store contents arrive as inputs.
`timescale 1ns/100ps
module pwp_core
    import pwp_pkg::*;
#(
    parameter int RETRY_STEP_CYC = PWP_RETRY_STEP_CYC,
    parameter logic [31:0] LOCK_KEY = 32'h50574b59
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [255:0] cmd_wdata,
    output logic [255:0] cmd_rdata,
    output logic cmd_done,
    output logic cmd_write_ok,
    output logic cmd_refused,
    input wire logic [15:0] driver_supply_monitor,
    input wire logic [15:0] driver_supply_low_threshold,
    input wire logic [255:0] dflt_mask,
    input wire logic [71:0] dflt_key,
    input wire logic output_on_req,
    input wire logic clear_faults,
    output logic output_enable,
    output logic alert_out_n,
    output logic supply_low_fault,
    output logic supply_low_warn,
    output logic [1:0] protection_level
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        pwp_state_t st;
        logic [7:0] action;
        logic [1:0] level;
        logic [71:0] user_key;
        logic [31:0] lock_key;
        logic [255:0] user_mask;
        logic [255:0] dflt_mask;
        logic [255:0] rdata;
        logic done;
        logic wr_ok;
        logic refused;
        logic [2:0] retry_left;
        logic [31:0] tmr;
        logic out_en;
        logic fault;
        logic warn;
    } pwp_regs_t;

    localparam pwp_regs_t REGS_RST = '{
        st: PWP_ST_RUN, action: PWP_ACTION_RST, level: PWP_LVL_OPEN,
        user_key: PWP_USER_KEY_RST, lock_key: PWP_LOCK_KEY_RST,
        user_mask: PWP_MASK_RST, dflt_mask: PWP_MASK_RST, rdata: 256'h0,
        done: 1'b0, wr_ok: 1'b0, refused: 1'b0, retry_left: 3'h0,
        tmr: 32'h0, out_en: 1'b0, fault: 1'b0, warn: 1'b0};

    pwp_regs_t r_q;
    pwp_regs_t r_d;
    pwp_guard_if gi ();

    // ----------------------------------------
    // Threshold compare
    // ----------------------------------------
    // Scale both sides by percent to avoid a divider
    logic [23:0] mon_pct;
    logic [23:0] thr_resume;
    logic [23:0] thr_warn;
    logic [23:0] thr_fault;
    logic uv_now;
    logic above_resume;
    logic below_warn;
    logic [1:0] resp;
    logic [2:0] retries;
    logic [2:0] rtime;
    logic [31:0] delay_cyc;
    logic wr;

    assign mon_pct = 24'(driver_supply_monitor) * 24'(PWP_PCT_FULL);
    assign thr_fault = 24'(driver_supply_low_threshold) * 24'(PWP_PCT_FULL);
    assign thr_resume = 24'(driver_supply_low_threshold) * 24'(PWP_PCT_RESUME);
    assign thr_warn = 24'(driver_supply_low_threshold) * 24'(PWP_PCT_WARN);
    assign uv_now = (mon_pct < thr_fault);
    assign above_resume = (mon_pct > thr_resume);
    assign below_warn = (mon_pct < thr_warn);

    assign resp = r_q.action[PWP_RESP_MSB:PWP_RESP_LSB];
    assign retries = r_q.action[PWP_RETRY_MSB:PWP_RETRY_LSB];
    assign rtime = r_q.action[PWP_RTIME_MSB:PWP_RTIME_LSB];
    assign delay_cyc = 32'((32'(rtime) + 32'h1) * 32'(RETRY_STEP_CYC));
    assign wr = cmd_valid && cmd_write;

    // ----------------------------------------
    // Write permission
    // ----------------------------------------
    assign gi.code = cmd_code;
    assign gi.level = r_q.level;
    assign gi.user_mask = r_q.user_mask;
    assign gi.dflt_mask = r_q.dflt_mask;

    pwp_guard u_guard (
        .gi(gi.guard)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        r_d = r_q;
        r_d.done = 1'b0;
        r_d.wr_ok = 1'b0;
        r_d.refused = 1'b0;
        r_d.warn = below_warn;

        if (cmd_valid && !cmd_write) begin
            r_d.done = 1'b1;
            unique case (cmd_code)
                PWP_CMD_LOW_ACTION: r_d.rdata = 256'(r_q.action);
                PWP_CMD_LEVEL: r_d.rdata = 256'(r_q.level);
                PWP_CMD_USER_KEY: r_d.rdata = 256'(r_q.user_key);
                PWP_CMD_LOCK_KEY: r_d.rdata = 256'(r_q.lock_key);
                PWP_CMD_WRITE_MASK: r_d.rdata = r_q.user_mask;
                default: r_d.rdata = 256'h0;
            endcase
        end

        if (wr) begin
            r_d.done = 1'b1;
            unique case (cmd_code)
                // public key raises to level 1
                PWP_CMD_LOCK_KEY: begin
                    r_d.lock_key = cmd_wdata[PWP_LOCK_KEY_W-1:0];
                    r_d.wr_ok = 1'b1;
                    if (cmd_wdata[PWP_LOCK_KEY_W-1:0] == LOCK_KEY &&
                        r_q.level < PWP_LVL_PUBLIC) begin
                        r_d.level = PWP_LVL_PUBLIC;
                    end
                end
                PWP_CMD_USER_KEY: begin
                    r_d.wr_ok = 1'b1;
                    if (cmd_wdata[PWP_USER_KEY_W-1:0] == dflt_key) begin
                        r_d.level = PWP_LVL_VENDOR;
                    end else if (r_q.level >= PWP_LVL_USER && gi.allowed) begin
                        r_d.user_key = cmd_wdata[PWP_USER_KEY_W-1:0];
                    end else if (cmd_wdata[PWP_USER_KEY_W-1:0] == r_q.user_key) begin
                        r_d.level = PWP_LVL_USER;
                    end else begin
                        r_d.wr_ok = 1'b0;
                        r_d.refused = 1'b1;
                    end
                end
                PWP_CMD_WRITE_MASK: begin
                    if (r_q.level >= PWP_LVL_VENDOR && gi.allowed) begin
                        r_d.dflt_mask = cmd_wdata;
                        r_d.wr_ok = 1'b1;
                    end else if (r_q.level >= PWP_LVL_USER && gi.allowed) begin
                        r_d.user_mask = cmd_wdata;
                        r_d.wr_ok = 1'b1;
                    end else begin
                        r_d.refused = 1'b1;
                    end
                end
                PWP_CMD_LEVEL: r_d.refused = 1'b1;
                default: begin
                    if (gi.allowed) begin
                        r_d.wr_ok = 1'b1;
                        if (cmd_code == PWP_CMD_LOW_ACTION) begin
                            r_d.action = cmd_wdata[7:0];
                            r_d.retry_left = cmd_wdata[PWP_RETRY_MSB:PWP_RETRY_LSB];
                        end
                    end else begin
                        r_d.refused = 1'b1;
                    end
                end
            endcase
        end

        // Default store contents reload while below vendor level
        if (r_q.level < PWP_LVL_VENDOR) begin
            r_d.dflt_mask = dflt_mask;
        end

        // Clearing reloads the retry budget
        if (clear_faults || !output_on_req) begin
            r_d.retry_left = retries;
        end

        // ----------------------------------------
        // Fault response
        // ----------------------------------------
        unique case (r_q.st)
            PWP_ST_RUN: begin
                r_d.out_en = output_on_req;
                if (uv_now && r_q.out_en) begin
                    if (resp == PWP_RESP_RETRY) begin
                        r_d.out_en = 1'b0;
                        if (retries == PWP_RETRY_NONE) begin
                            r_d.st = PWP_ST_HOLD;
                        end else if (retries == PWP_RETRY_FOREVER) begin
                            r_d.st = PWP_ST_WAIT;
                            r_d.tmr = delay_cyc;
                        end else if (r_q.retry_left != 3'h0) begin
                            r_d.st = PWP_ST_WAIT;
                            r_d.tmr = delay_cyc;
                            r_d.retry_left = r_q.retry_left - 3'h1;
                        end else begin
                            r_d.st = PWP_ST_HOLD;
                        end
                    end else if (resp == PWP_RESP_RESUME) begin
                        r_d.out_en = 1'b0;
                        r_d.st = PWP_ST_RESUME;
                    end
                end
            end
            PWP_ST_WAIT: begin
                r_d.out_en = 1'b0;
                if (!output_on_req) begin
                    r_d.st = PWP_ST_RUN;
                end else if (r_q.tmr <= 32'h1) begin
                    r_d.st = PWP_ST_RUN;
                    r_d.out_en = 1'b1;
                end else begin
                    r_d.tmr = r_q.tmr - 32'h1;
                end
            end
            PWP_ST_HOLD: begin
                r_d.out_en = 1'b0;
                if (clear_faults || !output_on_req) begin
                    r_d.st = PWP_ST_RUN;
                end
            end
            PWP_ST_RESUME: begin
                r_d.out_en = 1'b0;
                if (above_resume || !output_on_req) begin
                    r_d.st = PWP_ST_RUN;
                    r_d.out_en = output_on_req;
                end
            end
        endcase

        // sticky flag, set wins over clear
        if (clear_faults) begin
            r_d.fault = 1'b0;
        end
        if (uv_now) begin
            r_d.fault = 1'b1;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            r_q <= REGS_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign cmd_rdata = r_q.rdata;
    assign cmd_done = r_q.done;
    assign cmd_write_ok = r_q.wr_ok;
    assign cmd_refused = r_q.refused;
    assign output_enable = r_q.out_en;
    assign alert_out_n = !r_q.fault;
    assign supply_low_fault = r_q.fault;
    assign supply_low_warn = r_q.warn;
    assign protection_level = r_q.level;
endmodule

// ===== sim/pwp_host_model.sv
// Purpose: Host side of the command port.
// Assumes: One command at a time, one cycle pulse.
// Notes: Released lines carry inverted data.
`timescale 1ns/100ps
module pwp_host_model
    import pwp_pkg::*;
(
    input wire logic clock,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [255:0] cmd_wdata,
    input wire logic [255:0] cmd_rdata,
    input wire logic cmd_done,
    input wire logic cmd_write_ok,
    input wire logic cmd_refused
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = '0;
    end
    task automatic xfer(input logic w, input logic [7:0] c, input logic [255:0] d,
        output logic [1:0] res, output logic [255:0] rd);
        @(posedge clock);
        #1;
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code = c;
        cmd_wdata = d;
        @(posedge clock);
        #1;
        cmd_valid = 1'b0;
        cmd_code = ~c;
        cmd_wdata = ~d;
        rd = cmd_rdata;
        res = {cmd_refused, cmd_write_ok};
        // Answer must stand in the very next cycle
        if (cmd_done !== 1'b1) begin
            res = 2'h3;
        end
    endtask
endmodule

// ===== sim/pwp_core_asserts.sv
// Purpose: Port checks of pwp_core.
// Assumes: One clock domain.
// Notes: Bound to every pwp_core.
`timescale 1ns/100ps
module pwp_core_asserts
    import pwp_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_done,
    input wire logic cmd_write_ok,
    input wire logic cmd_refused,
    input wire logic [15:0] driver_supply_monitor,
    input wire logic [15:0] driver_supply_low_threshold,
    input wire logic output_enable,
    input wire logic alert_out_n,
    input wire logic supply_low_fault,
    input wire logic supply_low_warn,
    input wire logic [1:0] protection_level
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (!arst_n);
    chk_done_follows: assert property (cmd_valid |=> cmd_done)
        else $error("done missing");
    chk_done_cause: assert property (cmd_done |-> $past(cmd_valid))
        else $error("done without command");
    chk_level_ro: assert property (
        cmd_valid && cmd_write && cmd_code == PWP_CMD_LEVEL |=> cmd_refused && !cmd_write_ok)
        else $error("level write taken");
    chk_read_quiet: assert property (
        cmd_valid && !cmd_write |=> !cmd_write_ok && !cmd_refused) else $error("read flagged");
    chk_write_answer: assert property (
        cmd_valid && cmd_write |=> cmd_write_ok != cmd_refused) else $error("write answer");
    chk_level_keep: assert property (
        protection_level >= $past(protection_level)) else $error("level dropped");
    chk_fault_sets: assert property (
        driver_supply_monitor < driver_supply_low_threshold |=> supply_low_fault && !alert_out_n)
        else $error("fault not flagged");
    chk_alert_flag: assert property (
        alert_out_n == !supply_low_fault) else $error("alert mismatch");
    chk_warn_calc: assert property (
        1'b1 |=> supply_low_warn == (32'($past(driver_supply_monitor)) * PWP_PCT_FULL
        < 32'($past(driver_supply_low_threshold)) * PWP_PCT_WARN)) else $error("warn wrong");
    cov_fault: cover property ($rose(supply_low_fault));
    cov_vendor: cover property (protection_level == PWP_LVL_VENDOR);
    cov_restart: cover property ($rose(output_enable));
endmodule
bind pwp_core pwp_core_asserts u_chk (.clock(clock), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_done(cmd_done),
    .cmd_write_ok(cmd_write_ok), .cmd_refused(cmd_refused),
    .driver_supply_monitor(driver_supply_monitor),
    .driver_supply_low_threshold(driver_supply_low_threshold),
    .output_enable(output_enable), .alert_out_n(alert_out_n),
    .supply_low_fault(supply_low_fault), .supply_low_warn(supply_low_warn),
    .protection_level(protection_level));

// ===== sim/pwp_core_tb.sv
// Purpose: Self-checking bench of pwp_core.
// Assumes: Retry step shortened to STEP cycles.
// Notes: Table rows first, fault cases after.
`timescale 1ns/100ps
module pwp_core_tb;
    import pwp_pkg::*;
    localparam int STEP = 4;
    // Key values are arbitrary
    localparam logic [71:0] DKEY = 72'h6b65795f64666c7421;
    localparam logic [71:0] UKEY = 72'h6b65795f7573657221;
    localparam logic [31:0] PKEY = 32'h50574b59;
    localparam logic [255:0] DMASK = ~((256'h1 << 8'h10) | (256'h1 << 8'hf9));
    localparam logic [255:0] UMASK = ~(256'h1 << 8'h20);
    localparam logic [1:0] RD = 2'h0;
    localparam logic [1:0] OK = 2'h1;
    localparam logic [1:0] NO = 2'h2;
    typedef struct {logic w; logic [7:0] c; logic [255:0] d; logic [1:0] r;} pwp_row_t;
    pwp_row_t rows[$];
    logic clock, arst_n, clear_faults, output_on_req, p;
    logic cmd_valid, cmd_write, cmd_done, cmd_write_ok, cmd_refused;
    logic output_enable, alert_out_n, supply_low_fault, supply_low_warn;
    logic [1:0] protection_level, res;
    logic [7:0] cmd_code;
    logic [15:0] mon, thr;
    logic [255:0] cmd_wdata, cmd_rdata, rd;
    int fail_count = 0;
    int n_checks = 0;
    int n;
    pwp_core #(.RETRY_STEP_CYC(STEP), .LOCK_KEY(PKEY)) dut (
        .clock(clock), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .cmd_done(cmd_done), .cmd_write_ok(cmd_write_ok), .cmd_refused(cmd_refused),
        .driver_supply_monitor(mon), .driver_supply_low_threshold(thr),
        .dflt_mask(DMASK), .dflt_key(DKEY), .output_on_req(output_on_req),
        .clear_faults(clear_faults), .output_enable(output_enable),
        .alert_out_n(alert_out_n), .supply_low_fault(supply_low_fault),
        .supply_low_warn(supply_low_warn), .protection_level(protection_level));
    pwp_host_model u_host (.clock(clock), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .cmd_done(cmd_done), .cmd_write_ok(cmd_write_ok), .cmd_refused(cmd_refused));
    // ----
    // Helpers
    // ----
    task automatic note(input logic bad, input string m);
        n_checks++;
        if (bad) begin
            fail_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic add(input logic w, input logic [7:0] c, input logic [255:0] d,
        input logic [1:0] r);
        rows.push_back('{w, c, d, r});
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic clr();
        clear_faults = 1'b1;
        tick(1);
        clear_faults = 1'b0;
        tick(2);
    endtask
    task automatic act(input logic [7:0] a);
        u_host.xfer(1'b1, PWP_CMD_LOW_ACTION, {248'h0, a}, res, rd);
        mon = 16'd1200;
        clr();
    endtask
    task automatic trip();
        mon = 16'd900;
        tick(2);
    endtask
    task automatic wait_on(input int k);
        n = 0;
        while (output_enable !== 1'b1 && n < k) begin
            tick(1);
            n++;
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        note(1'b1, "watchdog");
        stop_test();
    end
    initial begin
        arst_n = 1'b0;
        clear_faults = 1'b0;
        output_on_req = 1'b1;
        mon = 16'd1200;
        thr = 16'd1000;
        add(1'b0, 8'hfa, '0, RD);
        add(1'b1, 8'hf9, 256'h80, NO);
        add(1'b0, 8'hf9, '0, RD);
        add(1'b1, 8'hfa, 256'h3, NO);
        add(1'b1, 8'hfd, '0, NO);
        add(1'b1, 8'hfc, PKEY, OK);
        add(1'b0, 8'hfc, PKEY, RD);
        add(1'b0, 8'hfa, 256'h1, RD);
        add(1'b1, 8'hfb, 256'h1, NO);
        add(1'b1, 8'hfb, '0, OK);
        add(1'b0, 8'hfa, 256'h2, RD);
        add(1'b1, 8'hfd, UMASK, OK);
        add(1'b0, 8'hfd, UMASK, RD);
        add(1'b1, 8'h10, '0, NO);
        add(1'b1, 8'h20, '0, OK);
        add(1'b1, 8'hfb, DKEY, OK);
        add(1'b0, 8'hfa, 256'h3, RD);
        add(1'b1, 8'h10, '0, OK);
        add(1'b1, 8'hfb, UKEY, OK);
        add(1'b0, 8'hfb, UKEY, RD);
        add(1'b1, 8'hf9, 256'h80, OK);
        add(1'b0, 8'hf9, 256'h80, RD);
        tick(10);
        note(protection_level !== PWP_LVL_OPEN || alert_out_n !== 1'b1, "reset");
        arst_n = 1'b1;
        tick(2);
        foreach (rows[i]) begin
            u_host.xfer(rows[i].w, rows[i].c, rows[i].d, res, rd);
            note(res !== rows[i].r || (!rows[i].w && rd !== rows[i].d),
                $sformatf("row %0d", i));
        end
        $display("command table done");
        act(8'h89);
        trip();
        note(alert_out_n !== 1'b0 || supply_low_fault !== 1'b1, "flag");
        note(output_enable !== 1'b0, "off at fault");
        mon = 16'd1200;
        wait_on(30);
        note(n < 7 || n > 10, "retry delay");
        trip();
        mon = 16'd1200;
        tick(30);
        note(output_enable !== 1'b0, "retries used");
        clr();
        note(output_enable !== 1'b1 || alert_out_n !== 1'b1, "cleared");
        act(8'h80);
        trip();
        mon = 16'd1200;
        tick(30);
        note(output_enable !== 1'b0, "no retry");
        clr();
        note(output_enable !== 1'b1, "on after clear");
        act(8'hb8);
        mon = 16'd900;
        n = 0;
        p = 1'b1;
        repeat (150) begin
            tick(1);
            if (output_enable === 1'b1 && p !== 1'b1) n++;
            p = output_enable;
        end
        note(n < 10, "endless retry");
        // Dropping the request must end the endless retry loop
        output_on_req = 1'b0;
        tick(10);
        note(output_enable !== 1'b0, "retry stopped");
        output_on_req = 1'b1;
        tick(1);
        note(output_enable !== 1'b1, "retry re-armed");
        $display("retry tests done");
        act(8'hc0);
        trip();
        note(output_enable !== 1'b0, "resume off");
        mon = 16'd1040;
        tick(20);
        note(output_enable !== 1'b0, "below resume");
        mon = 16'd1060;
        tick(3);
        note(output_enable !== 1'b1, "resumed");
        act(8'h00);
        trip();
        note(output_enable !== 1'b1 || alert_out_n !== 1'b0, "ignore");
        mon = 16'd1090;
        tick(2);
        note(supply_low_warn !== 1'b1, "warn on");
        mon = 16'd1110;
        tick(2);
        note(supply_low_warn !== 1'b0, "warn off");
        arst_n = 1'b0;
        tick(1);
        note(protection_level !== PWP_LVL_OPEN || alert_out_n !== 1'b1, "reset again");
        arst_n = 1'b1;
        tick(2);
        $display("mode tests done");
        stop_test();
    end
endmodule
